// *** dv/npx_exec_assertions.sv ***
`timescale 1ns/10ps
module npx_exec_assertions
   import npx_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR_WORD,
   input wire logic EXT_SET_EN,
   input wire logic [3:0] BANK_SELECT_REGISTER,
   input wire logic [11:0] INDEX_BASE,
   input wire logic [7:0] MEM_RDATA,
   input wire logic PUSH_REQ,
   input wire logic [11:0] MEM_ADDR,
   input wire logic MEM_RD,
   input wire logic [7:0] MEM_WDATA,
   input wire logic MEM_WR,
   input wire logic [4:0] FLAGS,
   input wire logic [PC_W-1:0] STACK_TOP_ENTRY,
   input wire logic [4:0] STACK_DEPTH_OUT,
   input wire logic BUSY,
   input wire logic DONE
);
   // ----------------------------------------
   // Accepted requests and operand fields
   // ----------------------------------------
   wire logic take = INSTR_VALID && !BUSY;
   wire logic neg = take && (INSTR_WORD[OPC_MSB:OPC_LSB] == NEG_OPC);
   wire logic idle = take && (INSTR_WORD == IDLE_OPC || INSTR_WORD[15:12] == IDLE_ALT_OPC);
   wire logic [7:0] f = INSTR_WORD[7:0];
   wire logic [11:0] acc = {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
   wire logic idx = EXT_SET_EN && (f <= IDX_LIMIT);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Negate timeline and addressing, then pop and idle checks
   a_neg_read: assert property (neg |=> MEM_RD && BUSY) else $error("no read");
   a_access_bank: assert property (
      neg && !INSTR_WORD[ABIT_POS] && !idx |=> MEM_ADDR == $past(acc))
      else $error("bad access address");
   a_bank_reg: assert property (
      neg && INSTR_WORD[ABIT_POS] |=> MEM_ADDR == {$past(BANK_SELECT_REGISTER), $past(f)})
      else $error("bad bank");
   a_indexed_addr: assert property (
      neg && !INSTR_WORD[ABIT_POS] && idx |=> MEM_ADDR == $past(INDEX_BASE) + {4'h0, $past(f)})
      else $error("bad index");
   a_write_back: assert property (
      MEM_RD |=> MEM_WR && $stable(MEM_ADDR) ##1 DONE && !BUSY)
      else $error("no write back");
   a_neg_value: assert property (
      MEM_WR |-> MEM_WDATA == 8'(~$past(MEM_RDATA) + 8'h01)
      && FLAGS[FLG_Z] == (MEM_WDATA == 8'h00) && FLAGS[FLG_N] == MEM_WDATA[7])
      else $error("bad negate");
   a_pop_step: assert property (
      take && INSTR_WORD == POP_OPC && !PUSH_REQ && STACK_DEPTH_OUT != 5'h00
      |=> DONE && STACK_DEPTH_OUT == $past(STACK_DEPTH_OUT) - 5'h01)
      else $error("bad pop");
   a_idle_quiet: assert property (
      idle && !PUSH_REQ |=> DONE && !MEM_WR && $stable(FLAGS) && $stable(STACK_TOP_ENTRY))
      else $error("idle changed state");
endmodule : npx_exec_assertions

// *** dv/tb_npx_exec.sv ***
`timescale 1ns/10ps
module tb_npx_exec
   import npx_pkg::*;
();
   // ----------------------------------------
   // Stimulus, notes and result checking
   // ----------------------------------------
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ext = 1'b0, push = 1'b0, rd, wr, busy, done;
   logic [15:0] word = 16'h0000;
   logic [3:0] bank_sel = 4'h0;
   logic [11:0] base = 12'h000, addr;
   logic [7:0] rdata = 8'h00, wdata;
   logic [PC_W-1:0] pval = '0, top;
   logic [4:0] flags, depth;
   logic [7:0] fs [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF};
   logic [7:0] vs [4] = '{8'h00, 8'h80, 8'h3A, 8'h10};
   logic [24:0] notes [$];
   int seed = 6757;
   int bad_count = 0;
   int checks_done = 0;
   // Free running 125 MHz clock
   always #4 clk = ~clk;
   // Block under test, every port driven or watched here
   npx_exec u_dut (.CORE_CLK(clk), .RESET(rst), .INSTR_VALID(vld), .INSTR_WORD(word),
      .EXT_SET_EN(ext), .BANK_SELECT_REGISTER(bank_sel), .INDEX_BASE(base), .MEM_RDATA(rdata),
      .PUSH_REQ(push), .PUSH_VALUE(pval), .MEM_ADDR(addr), .MEM_RD(rd), .MEM_WDATA(wdata),
      .MEM_WR(wr), .FLAGS(flags), .STACK_TOP_ENTRY(top), .STACK_DEPTH_OUT(depth),
      .BUSY(busy), .DONE(done));
   // Four-state compare, so an unknown output counts as a mismatch
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Single exit point for the finished and the timed-out run
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // One request, then a bounded wait for completion
   task automatic issue(input logic [15:0] w);
      @(posedge clk);
      word <= w;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      for (int i = 0; i < 6 && done !== 1'b1; i++) @(posedge clk);
      check({31'h0, done}, 32'h1);
   endtask : issue
   // Settings are random but held for the whole negate
   task automatic negate(input logic a, input logic x, input logic [7:0] f, input logic [7:0] v);
      logic [3:0] b;
      logic [11:0] p, ea;
      logic [7:0] r;
      b = 4'($random(seed));
      p = 12'($random(seed));
      ea = a ? {b, f} : (x && f <= IDX_LIMIT) ? p + {4'h0, f} :
         {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
      r = ~v + 8'h01;
      bank_sel <= b;
      base <= p;
      ext <= x;
      rdata <= v;
      notes.push_back({ea, r, r[7], v == 8'h80, r == 8'h00,
         v[3:0] == 4'h0, v == 8'h00});
      issue({NEG_OPC, a, f});
   endtask : negate
   // Oldest note against each write; negedge avoids the update race
   always @(negedge clk)
      if (wr === 1'b1) check({7'h0, addr, wdata, flags}, {7'h0, notes.pop_front()});
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++)
         negate(i[0], i[1], fs[i[3:2]], (i < 4) ? vs[i] : 8'($random(seed)));
      for (int i = 1; i <= 3; i++)
      begin
         @(posedge clk);
         pval <= PC_W'(i * 'h1111);
         push <= 1'b1;
      end
      @(posedge clk);
      push <= 1'b0;
      issue(IDLE_OPC);
      issue({IDLE_ALT_OPC, 12'($random(seed))});
      check({6'h0, depth, top}, {6'h0, 5'h03, 21'h03333});
      for (int k = 3; k >= 0; k--)
      begin
         issue(POP_OPC);
         check({6'h0, depth, top},
            {6'h0, 5'(k > 0 ? k - 1 : 0), 21'((k > 0 ? k - 1 : 0) * 'h1111)});
      end
      check(32'(notes.size()), 32'h0);
      complete_run();
   end
   // Watchdog, well beyond the roughly 110 cycles the run needs
   initial
   begin
      repeat (2000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule : tb_npx_exec
bind npx_exec npx_exec_assertions u_chk
(
   .CORE_CLK(CORE_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
   .EXT_SET_EN(EXT_SET_EN), .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER),
   .INDEX_BASE(INDEX_BASE), .MEM_RDATA(MEM_RDATA), .PUSH_REQ(PUSH_REQ),
   .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR),
   .FLAGS(FLAGS), .STACK_TOP_ENTRY(STACK_TOP_ENTRY), .STACK_DEPTH_OUT(STACK_DEPTH_OUT),
   .BUSY(BUSY), .DONE(DONE)
);

// *** hw/npx_exec.sv ***
`timescale 1ns/10ps
// Function
// - Negate replaces addressed byte with two's complement, updating N OV C DC Z.
// - Negate decoded from bits 15:9 = 0110110, then bank bit, then address.
// - Result is written back to the operand location, never to W.
// - Bank bit 0 selects the fixed access bank.
// - Bank bit 1 takes upper address bits from the bank select register.
// - Extended set, bank bit 0, address <= 95: indexed literal offset addressing.
// - Pop 0x0006 removes top return stack entry and discards it unless a push arrives in the same cycle; a push to a full stack is dropped and the pop goes ahead.
// - After pop the previous entry is the stack top; depth drops by one.
module npx_exec
   import npx_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR_WORD,
   input wire logic EXT_SET_EN,
   input wire logic [3:0] BANK_SELECT_REGISTER,
   input wire logic [11:0] INDEX_BASE,
   input wire logic [7:0] MEM_RDATA,
   input wire logic PUSH_REQ,
   input wire logic [PC_W-1:0] PUSH_VALUE,
   output logic [11:0] MEM_ADDR,
   output logic MEM_RD,
   output logic [7:0] MEM_WDATA,
   output logic MEM_WR,
   output logic [4:0] FLAGS,
   output logic [PC_W-1:0] STACK_TOP_ENTRY,
   output logic [4:0] STACK_DEPTH_OUT,
   output logic BUSY,
   output logic DONE
);
   // One-hot states; an illegal code falls back to idle through the default
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } npx_state_type;

   // Sequencer registers
   npx_state_type state_q, state_d;
   logic [11:0] addr_q, addr_d;
   logic rd_q, rd_d, wr_q, wr_d, busy_q, busy_d, done_q, done_d;
   logic [7:0] wdata_q, wdata_d;
   logic [4:0] flags_q, flags_d;
   // Return stack pointer, entries and top copy
   logic [4:0] sp_q, sp_d;
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic [PC_W-1:0] top_q, top_d;
   // Datapath and decode wires
   logic [7:0] neg_res;
   logic [4:0] neg_flags;
   logic is_neg, is_pop, bank_bit;
   logic [7:0] f_addr;
   logic [11:0] eff_addr;
   logic push_ok, pop_ok;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Opcode compares only; the sequencer decides when a word counts
   assign is_neg = (INSTR_WORD[OPC_MSB:OPC_LSB] == NEG_OPC);
   assign is_pop = (INSTR_WORD == POP_OPC);
   assign bank_bit = INSTR_WORD[ABIT_POS];
   assign f_addr = INSTR_WORD[7:0];

   // Effective address; indexed form wraps at 12 bits by design
   always_comb
   begin
      if (!bank_bit && EXT_SET_EN && f_addr <= IDX_LIMIT)
         eff_addr = INDEX_BASE + {4'h0, f_addr};
      else if (!bank_bit)
         eff_addr = {(f_addr < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f_addr};
      else
         eff_addr = {BANK_SELECT_REGISTER, f_addr};
   end

   // Negate datapath works on the byte the memory returns
   npx_neg_alu u_alu
   (
      .operand(MEM_RDATA),
      .result(neg_res),
      .flags(neg_flags)
   );

   // ----------------------------------------
   // Negate sequencer
   // ----------------------------------------
   // Read then write; memory data assumed valid in the same cycle as MEM_RD
   // Read data is not registered here, so the memory must answer in one cycle
   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      rd_d = 1'b0;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      flags_d = flags_q;
      busy_d = busy_q;
      done_d = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (INSTR_VALID && is_neg)
            begin
               addr_d = eff_addr;
               rd_d = 1'b1;
               busy_d = 1'b1;
               state_d = ST_READ;
            end
            // Unknown words take the idle path and only pulse DONE
            else if (INSTR_VALID)
               done_d = 1'b1;
         end
         ST_READ:
         begin
            wdata_d = neg_res;
            flags_d = neg_flags;
            wr_d = 1'b1;
            state_d = ST_WRITE;
         end
         ST_WRITE:
         begin
            busy_d = 1'b0;
            done_d = 1'b1;
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
         end
      endcase
   end

   // Sequencer registers; outputs are copies of these
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         state_q <= ST_IDLE;
         addr_q <= 12'h000;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
         flags_q <= FLAGS_RESET;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         flags_q <= flags_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   // ----------------------------------------
   // Return stack
   // ----------------------------------------
   // Pop on empty stack is ignored; push wins when both arrive together, unless the stack is full and the push is dropped
   // A pop reads the slot below the top, so the new top is ready in one cycle
   always_comb
   begin
      push_ok = PUSH_REQ && (sp_q < 5'(STACK_DEPTH)); // Full stack drops the push
      pop_ok = INSTR_VALID && is_pop && (state_q == ST_IDLE) && (sp_q != SP_RESET);
      sp_d = sp_q;
      top_d = top_q;
      if (push_ok)
      begin
         sp_d = sp_q + 5'h01;
         top_d = PUSH_VALUE;
      end
      else if (pop_ok)
      begin
         sp_d = sp_q - 5'h01;
         top_d = (sp_q > 5'h01) ? stack_q[sp_q - 5'h02] : '0;
      end
   end

   // Pointer and top copy; the top is a flop so its output needs no mux
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         sp_q <= SP_RESET;
         top_q <= '0;
      end
      else
      begin
         sp_q <= sp_d;
         top_q <= top_d;
      end
   end

   // Storage carries no reset; only entries below sp are ever read
   always_ff @(posedge CORE_CLK)
   begin
      if (push_ok)
         stack_q[sp_q] <= PUSH_VALUE;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Plain flop copies, no logic after the registers
   assign MEM_ADDR = addr_q;
   assign MEM_RD = rd_q;
   assign MEM_WDATA = wdata_q;
   assign MEM_WR = wr_q;
   assign FLAGS = flags_q;
   assign STACK_TOP_ENTRY = top_q;
   assign STACK_DEPTH_OUT = sp_q;
   assign BUSY = busy_q;
   assign DONE = done_q;
endmodule : npx_exec

// *** hw/npx_neg_alu.sv ***
`timescale 1ns/10ps
// Two's complement negate with status flags, computed as 0 - f
module npx_neg_alu
   import npx_pkg::*;
(
   input wire logic [7:0] operand,
   output logic [7:0] result,
   output logic [4:0] flags
);
   logic [8:0] full;
   logic [4:0] nib;
   // ----------------------------------------
   // Subtraction from zero
   // ----------------------------------------
   always_comb
   begin
      full = 9'h000 - {1'b0, operand};
      nib = 5'h00 - {1'b0, operand[3:0]};
      result = full[7:0];
      flags = 5'h00;
      flags[FLG_C] = ~full[8];              // No borrow only for zero
      flags[FLG_DC] = ~nib[4];
      flags[FLG_Z] = (full[7:0] == 8'h00);
      flags[FLG_OV] = (operand == 8'h80);   // -128 cannot be negated
      flags[FLG_N] = full[7];
   end
endmodule : npx_neg_alu

// *** hw/npx_pkg.sv ***
package npx_pkg;
   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [6:0] NEG_OPC = 7'h36;        // 0110 110 in bits 15:9
   localparam logic [15:0] POP_OPC = 16'h0006;
   localparam logic [15:0] IDLE_OPC = 16'h0000;
   localparam logic [3:0] IDLE_ALT_OPC = 4'hF;    // 1111 xxxx xxxx xxxx
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 9;
   localparam int ABIT_POS = 8;
   // ----------------------------------------
   // Addressing
   // ----------------------------------------
   localparam logic [7:0] IDX_LIMIT = 8'h5F;      // Indexed mode for f <= 95
   localparam logic [7:0] ACC_SPLIT = 8'h60;      // Access bank low/high split
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam int ADDR_W = 12;
   localparam int STACK_DEPTH = 31;
   localparam int PC_W = 21;
   localparam logic [4:0] SP_RESET = 5'h00;
   // ----------------------------------------
   // Flag positions
   // ----------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
endpackage : npx_pkg
